// file: rtl/i2cra_pkg.sv
`default_nettype none
package i2cra_pkg;
  // ----------------------------------------
  // bus addressing and framing
  // ----------------------------------------
  localparam logic [6:0] SLAVE_ADDR = 7'h43;
  localparam logic RW_READ = 1'h1;
  localparam logic [3:0] BIT_CNT_ZERO = 4'h0;
  localparam logic [3:0] BYTE_LAST_BIT = 4'h7;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [7:0] ADDR_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int QTR_PERIOD_NS = 2500;
  localparam int QTR_CYC = (QTR_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [6:0] QTR_LAST = 7'(QTR_CYC - 1);
  localparam logic [6:0] QTR_ZERO = 7'h00;
  localparam logic [1:0] PHASE_ZERO = 2'h0;
  localparam logic [1:0] PHASE_LAST = 2'h3;
  // ----------------------------------------
  // master command codes
  // ----------------------------------------
  typedef enum logic [1:0] {
    CMD_START,
    CMD_STOP,
    CMD_WRITE,
    CMD_READ
  } i2cra_cmd_t;
endpackage
`default_nettype wire

// file: rtl/i2cra_bus_if.sv
`default_nettype none
interface i2cra_bus_if;
  // ----------------------------------------
  // open-drain drivers, high enable pulls low
  // ----------------------------------------
  logic m_scl_o;
  logic m_scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic s_sda_o;
  logic s_sda_oe;
  logic scl;
  logic sda;
  // ----------------------------------------
  // wired-and with pull-up
  // ----------------------------------------
  assign scl = ~(m_scl_oe & ~m_scl_o);
  assign sda = ~(m_sda_oe & ~m_sda_o) & ~(s_sda_oe & ~s_sda_o);
  modport master (
    output m_scl_o,
    output m_scl_oe,
    output m_sda_o,
    output m_sda_oe,
    input scl,
    input sda
  );
  modport slave (
    output s_sda_o,
    output s_sda_oe,
    input scl,
    input sda
  );
endinterface
`default_nettype wire

// file: rtl/i2cra_master.sv
`default_nettype none
module i2cra_master (
  input wire logic clock_i,
  input wire logic reset_i,
  i2cra_bus_if.master bus,
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input wire i2cra_pkg::i2cra_cmd_t cmd_i,
  input wire logic [7:0] cmd_data_i,
  input wire logic cmd_ack_i,
  output logic rsp_valid_o,
  output logic [7:0] rsp_data_o,
  output logic rsp_nack_o
);
  typedef enum logic [1:0] {
    M_IDLE,
    M_START,
    M_STOP,
    M_BYTE
  } i2cra_mstate_t;

  i2cra_mstate_t state_ff;
  logic [6:0] qcnt_ff;
  logic [1:0] phase_ff;
  logic [3:0] bit_ff;
  logic [8:0] tx_ff;
  logic [8:0] rx_ff;
  logic scl_low_ff;
  logic sda_low_ff;
  logic [2:0] sda_sync_ff;
  logic sda_ff;
  logic tick;
  logic accept;

  // ----------------------------------------
  // pins and handshake
  // ----------------------------------------
  assign bus.m_scl_o = 1'h0;
  assign bus.m_sda_o = 1'h0;
  assign bus.m_scl_oe = scl_low_ff;
  assign bus.m_sda_oe = sda_low_ff;
  assign cmd_ready_o = (state_ff == M_IDLE);
  assign accept = cmd_valid_i & cmd_ready_o;
  assign tick = (state_ff != M_IDLE) && (qcnt_ff == i2cra_pkg::QTR_LAST);

  // ----------------------------------------
  // data line synchroniser
  // ----------------------------------------
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      sda_sync_ff <= 3'h7;
      sda_ff <= 1'h1;
    end else begin
      sda_sync_ff <= {sda_sync_ff[1:0], bus.sda};
      if (sda_sync_ff[1] == sda_sync_ff[2]) begin
        sda_ff <= sda_sync_ff[2];
      end
    end
  end

  // ----------------------------------------
  // quarter-period divider
  // ----------------------------------------
  always_ff @(posedge clock_i) begin
    if (reset_i || state_ff == M_IDLE || tick) begin
      qcnt_ff <= i2cra_pkg::QTR_ZERO;
    end else begin
      qcnt_ff <= qcnt_ff + 7'h01;
    end
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      state_ff <= M_IDLE;
      phase_ff <= i2cra_pkg::PHASE_ZERO;
      bit_ff <= i2cra_pkg::BIT_CNT_ZERO;
      tx_ff <= 9'h1FF;
      rx_ff <= 9'h000;
      scl_low_ff <= 1'h0;
      sda_low_ff <= 1'h0;
      rsp_valid_o <= 1'h0;
      rsp_data_o <= i2cra_pkg::DATA_RESET;
      rsp_nack_o <= 1'h0;
    end else begin
      rsp_valid_o <= 1'h0;
      if (accept) begin
        phase_ff <= i2cra_pkg::PHASE_ZERO;
        bit_ff <= i2cra_pkg::BIT_CNT_ZERO;
        case (cmd_i)
          i2cra_pkg::CMD_START: state_ff <= M_START;
          i2cra_pkg::CMD_STOP: state_ff <= M_STOP;
          i2cra_pkg::CMD_WRITE: begin
            state_ff <= M_BYTE;
            tx_ff <= {cmd_data_i, 1'h1};
          end
          i2cra_pkg::CMD_READ: begin
            state_ff <= M_BYTE;
            tx_ff <= {8'hFF, ~cmd_ack_i};
          end
          default: state_ff <= M_IDLE;
        endcase
      end else if (tick) begin
        phase_ff <= phase_ff + 2'h1;
        case (state_ff)
          M_START: begin
            case (phase_ff)
              2'h0: begin
                scl_low_ff <= 1'h1;
                sda_low_ff <= 1'h0;
              end
              2'h1: scl_low_ff <= 1'h0;
              2'h2: sda_low_ff <= 1'h1;
              default: scl_low_ff <= 1'h1;
            endcase
          end
          M_STOP: begin
            case (phase_ff)
              2'h0: begin
                scl_low_ff <= 1'h1;
                sda_low_ff <= 1'h1;
              end
              2'h1: scl_low_ff <= 1'h0;
              2'h2: sda_low_ff <= 1'h0;
              default: scl_low_ff <= 1'h0;
            endcase
          end
          M_BYTE: begin
            case (phase_ff)
              2'h0: begin
                scl_low_ff <= 1'h1;
                sda_low_ff <= ~tx_ff[8];
                tx_ff <= {tx_ff[7:0], 1'h1};
              end
              2'h1: scl_low_ff <= 1'h0;
              2'h2: rx_ff <= {rx_ff[7:0], sda_ff};
              default: bit_ff <= bit_ff + 4'h1;
            endcase
          end
          default: scl_low_ff <= scl_low_ff;
        endcase
        if (phase_ff == i2cra_pkg::PHASE_LAST) begin
          if (state_ff != M_BYTE || bit_ff == i2cra_pkg::BYTE_BITS) begin
            state_ff <= M_IDLE;
            rsp_valid_o <= 1'h1;
            if (state_ff == M_BYTE) begin
              rsp_data_o <= rx_ff[8:1];
              rsp_nack_o <= rx_ff[0];
            end
          end
        end
      end
    end
  end
endmodule // i2cra_master
`default_nettype wire

// file: rtl/i2cra_slave.sv
`default_nettype none
module i2cra_slave (
  input wire logic clock_i,
  input wire logic reset_i,
  i2cra_bus_if.slave bus,
  output logic [7:0] reg_addr_o,
  output logic [7:0] reg_wdata_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  input wire logic [7:0] reg_rdata_i,
  output logic busy_o
);
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RX,
    ST_ACK,
    ST_TX,
    ST_MACK
  } i2cra_sstate_t;

  typedef enum logic [1:0] {
    PH_SEL,
    PH_REG,
    PH_DATA
  } i2cra_phase_t;

  i2cra_sstate_t state_ff;
  i2cra_phase_t phase_ff;
  logic [2:0] scl_sync_ff;
  logic [2:0] sda_sync_ff;
  logic scl_ff;
  logic sda_ff;
  logic scl_d_ff;
  logic sda_d_ff;
  logic [3:0] bit_cnt_ff;
  logic [7:0] shift_ff;
  logic rw_ff;
  logic mack_ff;
  logic sda_low_ff;
  logic [7:0] addr_ff;
  logic wr_ff;
  logic rd_ff;
  logic [7:0] wdata_ff;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic byte_end;
  logic tx_end;

  function automatic logic addr_match(input logic [7:0] sel);
    addr_match = (sel[7:1] == i2cra_pkg::SLAVE_ADDR);
  endfunction

  // ----------------------------------------
  // line synchronisers
  // ----------------------------------------
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      scl_sync_ff <= 3'h7;
      sda_sync_ff <= 3'h7;
      scl_ff <= 1'h1;
      sda_ff <= 1'h1;
      scl_d_ff <= 1'h1;
      sda_d_ff <= 1'h1;
    end else begin
      scl_sync_ff <= {scl_sync_ff[1:0], bus.scl};
      sda_sync_ff <= {sda_sync_ff[1:0], bus.sda};
      if (scl_sync_ff[1] == scl_sync_ff[2]) begin
        scl_ff <= scl_sync_ff[2];
      end
      if (sda_sync_ff[1] == sda_sync_ff[2]) begin
        sda_ff <= sda_sync_ff[2];
      end
      scl_d_ff <= scl_ff;
      sda_d_ff <= sda_ff;
    end
  end

  // ----------------------------------------
  // bus events
  // ----------------------------------------
  assign scl_rise = scl_ff & ~scl_d_ff;
  assign scl_fall = ~scl_ff & scl_d_ff;
  assign start_det = scl_ff & scl_d_ff & sda_d_ff & ~sda_ff;
  assign stop_det = scl_ff & scl_d_ff & ~sda_d_ff & sda_ff;
  assign byte_end = (state_ff == ST_RX) && scl_fall && (bit_cnt_ff == i2cra_pkg::BYTE_BITS);
  assign tx_end = (state_ff == ST_TX) && scl_fall && (bit_cnt_ff == i2cra_pkg::BYTE_LAST_BIT);

  // ----------------------------------------
  // pins, the clock line is never driven
  // ----------------------------------------
  assign bus.s_sda_o = 1'h0;
  assign bus.s_sda_oe = sda_low_ff;
  assign reg_addr_o = addr_ff;
  assign reg_wdata_o = wdata_ff;
  assign reg_wr_o = wr_ff;
  assign reg_rd_o = rd_ff;
  assign busy_o = (state_ff != ST_IDLE);

  // ----------------------------------------
  // transfer state machine
  // ----------------------------------------
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      state_ff <= ST_IDLE;
      phase_ff <= PH_SEL;
      bit_cnt_ff <= i2cra_pkg::BIT_CNT_ZERO;
      shift_ff <= i2cra_pkg::DATA_RESET;
      rw_ff <= 1'h0;
      mack_ff <= 1'h0;
      sda_low_ff <= 1'h0;
    end else if (stop_det) begin
      state_ff <= ST_IDLE;
      sda_low_ff <= 1'h0;
    end else if (start_det) begin
      state_ff <= ST_RX;
      phase_ff <= PH_SEL;
      bit_cnt_ff <= i2cra_pkg::BIT_CNT_ZERO;
      sda_low_ff <= 1'h0;
    end else begin
      case (state_ff)
        ST_IDLE: sda_low_ff <= 1'h0;
        ST_RX: begin
          if (scl_rise) begin
            shift_ff <= {shift_ff[6:0], sda_ff};
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
          end else if (byte_end) begin
            if (phase_ff == PH_SEL && !addr_match(shift_ff)) begin
              state_ff <= ST_IDLE;
            end else begin
              state_ff <= ST_ACK;
              sda_low_ff <= 1'h1;
              if (phase_ff == PH_SEL) begin
                rw_ff <= shift_ff[0];
                phase_ff <= PH_REG;
              end else begin
                phase_ff <= PH_DATA;
              end
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            bit_cnt_ff <= i2cra_pkg::BIT_CNT_ZERO;
            if (phase_ff == PH_REG && rw_ff == i2cra_pkg::RW_READ) begin
              state_ff <= ST_TX;
              shift_ff <= reg_rdata_i;
              sda_low_ff <= ~reg_rdata_i[7];
            end else begin
              state_ff <= ST_RX;
              sda_low_ff <= 1'h0;
            end
          end
        end
        ST_TX: begin
          if (tx_end) begin
            state_ff <= ST_MACK;
            sda_low_ff <= 1'h0;
            mack_ff <= 1'h0;
          end else if (scl_fall) begin
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
            shift_ff <= {shift_ff[6:0], 1'h0};
            sda_low_ff <= ~shift_ff[6];
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            mack_ff <= ~sda_ff;
          end else if (scl_fall) begin
            bit_cnt_ff <= i2cra_pkg::BIT_CNT_ZERO;
            if (mack_ff) begin
              state_ff <= ST_TX;
              shift_ff <= reg_rdata_i;
              sda_low_ff <= ~reg_rdata_i[7];
            end else begin
              state_ff <= ST_IDLE;
            end
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // register write strobe
  // ----------------------------------------
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      wr_ff <= 1'h0;
      wdata_ff <= i2cra_pkg::DATA_RESET;
    end else begin
      wr_ff <= 1'h0;
      if (byte_end && phase_ff == PH_DATA) begin
        wr_ff <= 1'h1;
        wdata_ff <= shift_ff;
      end
    end
  end

  // ----------------------------------------
  // register read strobe
  // ----------------------------------------
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      rd_ff <= 1'h0;
    end else begin
      rd_ff <= scl_fall && !start_det && !stop_det && (
        (state_ff == ST_ACK && phase_ff == PH_REG && rw_ff == i2cra_pkg::RW_READ) ||
        (state_ff == ST_MACK && mack_ff));
    end
  end

  // ----------------------------------------
  // byte address counter
  // ----------------------------------------
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      addr_ff <= i2cra_pkg::ADDR_RESET;
    end else if (byte_end && phase_ff == PH_REG && rw_ff != i2cra_pkg::RW_READ) begin
      addr_ff <= shift_ff;
    end else if (wr_ff || (tx_end && !start_det && !stop_det)) begin
      addr_ff <= addr_ff + 8'h01;
    end
  end
endmodule // i2cra_slave
`default_nettype wire

// file: testbench/i2cra_props.sv
`default_nettype none
module i2cra_props (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic m_scl_oe,
  input wire logic m_sda_oe,
  input wire logic s_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // bus observer
  // ----
  logic scl_ff, sda_ff, first_ff, rd_ff, bad_ff, done_ff, frame_ff;
  logic [3:0] bitn_ff;
  logic [7:0] byte_ff;
  logic scl_rise, start_seen, stop_seen;
  assign scl_rise = scl & ~scl_ff;
  assign start_seen = scl & scl_ff & sda_ff & ~sda;
  assign stop_seen = scl & scl_ff & ~sda_ff & sda;
  always_ff @(posedge clock_i) begin
    scl_ff <= scl;
    sda_ff <= sda;
  end
  // between a start and the next stop
  always_ff @(posedge clock_i) begin
    if (reset_i || stop_seen) begin
      frame_ff <= 1'h0;
    end else if (start_seen) begin
      frame_ff <= 1'h1;
    end
  end
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      bitn_ff <= 4'h0;
      byte_ff <= 8'h00;
      first_ff <= 1'h0;
      rd_ff <= 1'h0;
      bad_ff <= 1'h0;
      done_ff <= 1'h0;
    end else if (start_seen) begin
      bitn_ff <= 4'h0;
      first_ff <= 1'h1;
      bad_ff <= 1'h0;
      done_ff <= 1'h0;
    end else if (scl_rise && bitn_ff == 4'h8) begin
      bitn_ff <= 4'h0;
      first_ff <= 1'h0;
      if (first_ff) begin
        rd_ff <= byte_ff[0];
        bad_ff <= byte_ff[7:1] != i2cra_pkg::SLAVE_ADDR;
      end else if (rd_ff && sda) begin
        done_ff <= 1'h1;
      end
    end else if (scl_rise) begin
      bitn_ff <= bitn_ff + 4'h1;
      byte_ff <= {byte_ff[6:0], sda};
    end
  end
  // ----
  // properties
  // ----
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);
  AST_NO_INITIATE: assert property (!frame_ff |-> !s_sda_oe)
    else $error("slave drove data outside a transfer");
  AST_SDA_MOVES_LOW: assert property ($changed(s_sda_oe) |-> !scl)
    else $error("slave moved data while clock high");
  AST_SEL_QUIET: assert property (scl_rise && first_ff && bitn_ff < 4'h8 |-> !s_sda_oe)
    else $error("slave drove during selection byte");
  AST_SEL_ACK: assert property (scl_rise && first_ff && bitn_ff == 4'h8 |->
    s_sda_oe == (byte_ff[7:1] == i2cra_pkg::SLAVE_ADDR))
    else $error("selection acknowledge wrong");
  AST_MISMATCH_SILENT: assert property (bad_ff |-> !s_sda_oe)
    else $error("slave drove after address mismatch");
  AST_WRITE_ACK: assert property (scl_rise && bitn_ff == 4'h8 && !first_ff && !rd_ff && !bad_ff |-> s_sda_oe)
    else $error("written byte not acknowledged");
  AST_READ_MASTER_QUIET: assert property (scl_rise && bitn_ff < 4'h8 && !first_ff && rd_ff && !bad_ff && !done_ff
    |-> !m_sda_oe)
    else $error("master drove during read data");
  AST_READ_RELEASE: assert property (scl_rise && bitn_ff == 4'h8 && !first_ff && rd_ff && !bad_ff |-> !s_sda_oe)
    else $error("slave held data in master ack slot");
  AST_STOP_QUIET: assert property (stop_seen |-> (!s_sda_oe) [*8])
    else $error("slave drove after stop");
  cover property (start_seen);
  cover property (scl_rise && first_ff && bitn_ff == 4'h8 && !sda);
  cover property (bad_ff && scl_rise);
  cover property (done_ff && stop_seen);
endmodule // i2cra_props
`default_nettype wire

// file: testbench/i2c_register_access_slave_bench.sv
`default_nettype none
module i2c_register_access_slave_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // signals and instances
  // ----
  localparam logic [7:0] SEL_WR = {i2cra_pkg::SLAVE_ADDR, 1'h0};
  localparam logic [7:0] SEL_RD = {i2cra_pkg::SLAVE_ADDR, i2cra_pkg::RW_READ};
  localparam logic [7:0] SEL_BAD = {i2cra_pkg::SLAVE_ADDR ^ 7'h07, 1'h0};
  logic clock_i = 1'h0;
  logic reset_i = 1'h1;
  logic cmd_valid = 1'h0;
  i2cra_pkg::i2cra_cmd_t cmd = i2cra_pkg::CMD_START;
  logic [7:0] cmd_data = 8'h00;
  logic cmd_ack = 1'h0;
  logic cmd_ready, rsp_valid, rsp_nack, busy, reg_wr, reg_rd;
  logic [7:0] rsp_data, reg_addr, reg_wdata, reg_rdata;
  logic [7:0] mem [256];
  int miscompares = 0;
  int cmp_count = 0;
  int wr_count = 0;
  int rd_count = 0;
  i2cra_bus_if i_i2cra_bus_if ();
  i2cra_master i_i2cra_master (.clock_i(clock_i), .reset_i(reset_i), .bus(i_i2cra_bus_if),
    .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready), .cmd_i(cmd), .cmd_data_i(cmd_data), .cmd_ack_i(cmd_ack),
    .rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data), .rsp_nack_o(rsp_nack));
  i2cra_slave i_i2cra_slave (.clock_i(clock_i), .reset_i(reset_i), .bus(i_i2cra_bus_if),
    .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd),
    .reg_rdata_i(reg_rdata), .busy_o(busy));
  i2cra_props i_i2cra_props (.clock_i(clock_i), .reset_i(reset_i), .m_scl_oe(i_i2cra_bus_if.m_scl_oe),
    .m_sda_oe(i_i2cra_bus_if.m_sda_oe), .s_sda_oe(i_i2cra_bus_if.s_sda_oe),
    .scl(i_i2cra_bus_if.scl), .sda(i_i2cra_bus_if.sda));
  // ----
  // register file model
  // ----
  assign reg_rdata = mem[reg_addr];
  initial begin
    forever #10 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    if (reg_wr === 1'h1) begin
      mem[reg_addr] <= reg_wdata;
      wr_count <= wr_count + 1;
    end
    if (reg_rd === 1'h1) begin
      rd_count <= rd_count + 1;
    end
  end
  // ----
  // tasks
  // ----
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic do_cmd(input i2cra_pkg::i2cra_cmd_t c, input logic [7:0] d, input logic a);
    int n;
    @(posedge clock_i);
    #1;
    cmd_valid = 1'h1;
    cmd = c;
    cmd_data = d;
    cmd_ack = a;
    @(posedge clock_i);
    #1;
    cmd_valid = 1'h0;
    check({7'h00, cmd_ready}, 8'h00);
    n = 0;
    while (rsp_valid !== 1'h1 && n < 5000) begin
      @(posedge clock_i);
      #1;
      n++;
    end
    check({7'h00, n < 5000}, 8'h01);
  endtask
  task automatic send(input logic [7:0] d, input logic exp_nack);
    do_cmd(i2cra_pkg::CMD_WRITE, d, 1'h0);
    check({7'h00, rsp_nack}, {7'h00, exp_nack});
  endtask
  task automatic fetch(input logic a, input logic [7:0] exp);
    do_cmd(i2cra_pkg::CMD_READ, 8'h00, a);
    check(rsp_data, exp);
  endtask
  task automatic tally_and_finish();
    if (miscompares == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ----
  // tests
  // ----
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5A;
    repeat (10) @(posedge clock_i);
    #1;
    reset_i = 1'h0;
    repeat (5) @(posedge clock_i);
    do_cmd(i2cra_pkg::CMD_START, 8'h00, 1'h0);
    send(SEL_WR, 1'h0);
    send(8'h10, 1'h0);
    send(8'hA5, 1'h0);
    send(8'h3C, 1'h0);
    do_cmd(i2cra_pkg::CMD_STOP, 8'h00, 1'h0);
    check(mem[8'h10], 8'hA5);
    check(mem[8'h11], 8'h3C);
    check(8'(wr_count), 8'h02);
    check(reg_addr, 8'h12);
    check({7'h00, busy}, 8'h00);
    check({6'h00, i2cra_bus_if_lines()}, 8'h03);
    do_cmd(i2cra_pkg::CMD_START, 8'h00, 1'h0);
    send(SEL_WR, 1'h0);
    send(8'h10, 1'h0);
    do_cmd(i2cra_pkg::CMD_START, 8'h00, 1'h0);
    send(SEL_RD, 1'h0);
    fetch(1'h1, 8'hA5);
    fetch(1'h0, 8'h3C);
    do_cmd(i2cra_pkg::CMD_STOP, 8'h00, 1'h0);
    check(reg_addr, 8'h12);
    do_cmd(i2cra_pkg::CMD_START, 8'h00, 1'h0);
    send(SEL_RD, 1'h0);
    fetch(1'h0, 8'h12 ^ 8'h5A);
    do_cmd(i2cra_pkg::CMD_STOP, 8'h00, 1'h0);
    check(reg_addr, 8'h13);
    check(8'(rd_count), 8'h03);
    do_cmd(i2cra_pkg::CMD_START, 8'h00, 1'h0);
    send(SEL_BAD, 1'h1);
    send(8'h55, 1'h1);
    do_cmd(i2cra_pkg::CMD_STOP, 8'h00, 1'h0);
    check(8'(wr_count), 8'h02);
    check(reg_addr, 8'h13);
    tally_and_finish();
  end
  function automatic logic [1:0] i2cra_bus_if_lines();
    return {i_i2cra_bus_if.scl, i_i2cra_bus_if.sda};
  endfunction
  initial begin
    #(90000 * 20);
    miscompares++;
    $display("CHECK FAILED at %0t: run did not complete", $time);
    tally_and_finish();
  end
endmodule // i2c_register_access_slave_bench
`default_nettype wire
